// *** irms_top.sv ***
// Measurement sequencer and read-out handshake with register port
`timescale 1ns/100ps

module irms_top #(
  parameter int          NUM_BYTES = 10,
  parameter int          TW        = 32,
  parameter logic [TW-1:0] MEAS_CYC = TW'(irms_pkg::MEAS_BASE_CYC)
) (
  // Clock and reset
  input  wire logic        i_clock,
  input  wire logic        i_rst,
  // Register port
  input  wire logic [7:0]  i_addr,
  input  wire logic [7:0]  i_wdata,
  input  wire logic        i_wr,
  input  wire logic        i_rd,
  output logic      [7:0]  o_rdata,
  // Result from the converter
  input  wire logic [79:0] i_result,
  // Interrupt
  output logic             o_int,
  output logic             o_data_irq
);

  irms_pkg::irms_bus_s bus;
  assign bus = '{addr: i_addr, wdata: i_wdata, wr: i_wr, rd: i_rd};

  function automatic logic is_data(input logic [7:0] a);
    is_data = (a >= irms_pkg::ADDR_DATA_LO) && (a <= irms_pkg::ADDR_DATA_HI);
  endfunction

  // ----------------------------------------------------------------
  // Control registers
  // ----------------------------------------------------------------
  logic [7:0] ctrl_q, ctrl_d;
  logic [7:0] irq_en_q, irq_en_d;
  logic [1:0] irq_st_q, irq_st_d;
  logic [1:0] irq_msk_q, irq_msk_d;
  logic [2:0] measure_mode_sel;
  logic [2:0] filter_cutoff_sel;
  logic       mode_wr;

  assign measure_mode_sel  = ctrl_q[irms_pkg::CTRL_MODE_LSB +: 3];
  assign filter_cutoff_sel = ctrl_q[irms_pkg::CTRL_FC_LSB +: 3];
  assign mode_wr = bus.wr && (bus.addr == irms_pkg::ADDR_CTRL);

  // ----------------------------------------------------------------
  // Sequencer
  // ----------------------------------------------------------------
  irms_pkg::irms_seq_e st_q, st_d;
  logic [2:0]  wait_left_q, wait_left_d;
  logic        tm_load;
  logic        tm_stop;
  logic [TW-1:0] tm_count;
  logic        tm_done;
  logic        meas_end;
  logic        single_back;

  // Period grows with filter step; intermittent modes wait 1, 3, 7 slots
  assign tm_count = TW'(MEAS_CYC * (TW'(filter_cutoff_sel) + TW'(1)));

  function automatic logic [2:0] wait_slots(input logic [2:0] m);
    unique case (m)
      irms_pkg::MODE_CONT1: wait_slots = 3'h1;
      irms_pkg::MODE_CONT2: wait_slots = 3'h3;
      irms_pkg::MODE_CONT3: wait_slots = 3'h7;
      default:              wait_slots = 3'h0;
    endcase
  endfunction

  irms_timer #(.WIDTH(TW)) u_timer (
    .i_clock (i_clock),
    .i_rst   (i_rst),
    .i_load  (tm_load),
    .i_stop  (tm_stop),
    .i_count (tm_count),
    .o_done  (tm_done)
  );

  always_comb
  begin
    st_d        = st_q;
    wait_left_d = wait_left_q;
    tm_load     = 1'b0;
    tm_stop     = 1'b0;
    meas_end    = 1'b0;
    if (mode_wr)
    begin
      // Abort any running measurement; data registers untouched
      tm_stop = 1'b1;
      st_d    = irms_pkg::SEQ_IDLE;
    end
    else
    begin
      unique case (st_q)
        irms_pkg::SEQ_IDLE:
        begin
          if (measure_mode_sel == irms_pkg::MODE_SINGLE ||
              measure_mode_sel[2])
          begin
            st_d    = irms_pkg::SEQ_MEAS;
            tm_load = 1'b1;
          end
        end
        irms_pkg::SEQ_MEAS:
        begin
          if (tm_done)
          begin
            meas_end = 1'b1;
            if (measure_mode_sel == irms_pkg::MODE_CONT0)
            begin
              tm_load = 1'b1;
            end
            else if (measure_mode_sel[2])
            begin
              st_d        = irms_pkg::SEQ_WAIT;
              wait_left_d = wait_slots(measure_mode_sel);
              tm_load     = 1'b1;
            end
            else
            begin
              st_d = irms_pkg::SEQ_HOLD;
            end
          end
        end
        irms_pkg::SEQ_WAIT:
        begin
          if (tm_done)
          begin
            tm_load = 1'b1;
            if (wait_left_q <= 3'h1)
            begin
              st_d = irms_pkg::SEQ_MEAS;
            end
            else
            begin
              wait_left_d = wait_left_q - 3'h1;
            end
          end
        end
        irms_pkg::SEQ_HOLD:
        begin
          st_d = irms_pkg::SEQ_HOLD;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Result buffer, data registers and flags
  // ----------------------------------------------------------------
  logic [79:0] buf_q, buf_d;
  logic [79:0] data_q, data_d;
  logic        data_ready_flag_q, data_ready_flag_d;
  logic        dor_q, dor_d;
  logic        prot_q, prot_d;
  logic        rd_data, rd_st2, ro_start;
  logic [7:0]  rdata_d, rdata_q;
  logic        int_d, int_q, dirq_q;

  assign rd_data  = bus.rd && is_data(bus.addr);
  assign rd_st2   = bus.rd && (bus.addr == irms_pkg::ADDR_STATUS2);
  assign ro_start = (rd_data || rd_st2) && !prot_q;
  assign single_back = rd_st2 && (st_q == irms_pkg::SEQ_HOLD);

  always_comb
  begin
    buf_d  = buf_q;
    data_d = data_q;
    data_ready_flag_d = data_ready_flag_q;
    dor_d  = dor_q;
    prot_d = prot_q;
    if (ro_start)
    begin
      data_ready_flag_d = 1'b0;
      dor_d  = 1'b0;
      prot_d = 1'b1;
    end
    if (rd_st2)
    begin
      prot_d = 1'b0;
    end
    if (meas_end)
    begin
      buf_d = i_result;
      if (!prot_q && !ro_start)
      begin
        data_d = i_result;
        // Overrun sticks until the next read-out start clears it
        dor_d  = dor_q || data_ready_flag_q;
        data_ready_flag_d = 1'b1;
      end
      else
      begin
        dor_d = 1'b1;
      end
    end
  end

  // ----------------------------------------------------------------
  // Register writes, interrupts and read mux
  // ----------------------------------------------------------------
  always_comb
  begin
    ctrl_d    = ctrl_q;
    irq_en_d  = irq_en_q;
    irq_msk_d = irq_msk_q;
    irq_st_d  = irq_st_q;
    if (bus.wr)
    begin
      unique case (bus.addr)
        irms_pkg::ADDR_CTRL:    ctrl_d    = bus.wdata;
        irms_pkg::ADDR_IRQ_EN:  irq_en_d  = bus.wdata;
        irms_pkg::ADDR_IRQ_MSK: irq_msk_d = bus.wdata[1:0];
        irms_pkg::ADDR_IRQ_ST:  irq_st_d  = irq_st_q & ~bus.wdata[1:0];
        default:                ctrl_d    = ctrl_q;
      endcase
    end
    if (single_back)
    begin
      ctrl_d[irms_pkg::CTRL_MODE_LSB +: 3] = irms_pkg::MODE_STANDBY;
    end
    // Set beats clear in the same cycle
    if (meas_end)
    begin
      irq_st_d[irms_pkg::IRQ_EV_DONE] = 1'b1;
    end
    if (meas_end && (prot_q || data_ready_flag_q))
    begin
      irq_st_d[irms_pkg::IRQ_EV_SKIP] = 1'b1;
    end
    int_d = (irq_en_q[0] && data_ready_flag_d) || (|(irq_st_d & irq_msk_d));
    rdata_d = 8'h00;
    if (bus.rd)
    begin
      if (is_data(bus.addr))
      begin
        rdata_d = data_q[8*(bus.addr - irms_pkg::ADDR_DATA_LO) +: 8];
      end
      else
      begin
        unique case (bus.addr)
          irms_pkg::ADDR_STATUS1: rdata_d = {6'h00, dor_q, data_ready_flag_q};
          irms_pkg::ADDR_STATUS2: rdata_d = {6'h00, dor_q, prot_q};
          irms_pkg::ADDR_CTRL:    rdata_d = ctrl_q;
          irms_pkg::ADDR_IRQ_EN:  rdata_d = irq_en_q;
          irms_pkg::ADDR_IRQ_ST:  rdata_d = {6'h00, irq_st_q};
          irms_pkg::ADDR_IRQ_MSK: rdata_d = {6'h00, irq_msk_q};
          default:                rdata_d = 8'h00;
        endcase
      end
    end
  end

  always_ff @(posedge i_clock)
  begin
    if (i_rst)
    begin
      st_q        <= irms_pkg::SEQ_IDLE;
      wait_left_q <= 3'h0;
      ctrl_q      <= irms_pkg::CTRL_RESET;
      irq_en_q    <= irms_pkg::IRQ_EN_RESET;
      irq_msk_q   <= irms_pkg::IRQ_MSK_RESET;
      irq_st_q    <= 2'h0;
      buf_q       <= '0;
      data_q      <= '0;
      data_ready_flag_q      <= 1'b0;
      dor_q       <= 1'b0;
      prot_q      <= 1'b0;
      rdata_q     <= 8'h00;
      int_q       <= 1'b0;
      dirq_q      <= 1'b0;
    end
    else
    begin
      st_q        <= single_back ? irms_pkg::SEQ_IDLE : st_d;
      wait_left_q <= wait_left_d;
      ctrl_q      <= ctrl_d;
      irq_en_q    <= irq_en_d;
      irq_msk_q   <= irq_msk_d;
      irq_st_q    <= irq_st_d;
      buf_q       <= buf_d;
      data_q      <= data_d;
      data_ready_flag_q      <= data_ready_flag_d;
      dor_q       <= dor_d;
      prot_q      <= prot_d;
      rdata_q     <= rdata_d;
      int_q       <= int_d;
      dirq_q      <= irq_en_d[0] && data_ready_flag_d;
    end
  end

  assign o_rdata    = rdata_q;
  assign o_int      = int_q;
  assign o_data_irq = dirq_q;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  a_frozen_data: assert property (@(posedge i_clock) disable iff (i_rst)
    prot_q && !rd_st2 |=> $stable(data_q))
    else $error("data changed while protected");
  a_ready_set: assert property (@(posedge i_clock) disable iff (i_rst)
    meas_end && !prot_q && !ro_start |=> data_ready_flag_q && data_q == $past(i_result))
    else $error("result stored without ready");
  a_start_clear: assert property (@(posedge i_clock) disable iff (i_rst)
    ro_start && !meas_end |=> !data_ready_flag_q && !dor_q &&
      (prot_q != $past(rd_st2)))
    else $error("read-out start did not clear flags");
  a_skip_dor: assert property (@(posedge i_clock) disable iff (i_rst)
    meas_end && prot_q |=> dor_q)
    else $error("discarded result without overrun");
  a_abort_keep: assert property (@(posedge i_clock) disable iff (i_rst)
    mode_wr |=> st_q == irms_pkg::SEQ_IDLE ##1 $stable(data_q))
    else $error("mode write did not abort");
  a_unread_dor: assert property (@(posedge i_clock) disable iff (i_rst)
    meas_end && data_ready_flag_q && !prot_q && !ro_start |=> data_ready_flag_q && dor_q)
    else $error("skipped result not flagged");
  a_int_ready: assert property (@(posedge i_clock) disable iff (i_rst)
    irq_en_q[0] && data_ready_flag_q && !ro_start && !bus.wr |=> o_int)
    else $error("interrupt low with ready enabled");
  a_single_back: assert property (@(posedge i_clock) disable iff (i_rst)
    single_back && !mode_wr |=>
      measure_mode_sel == irms_pkg::MODE_STANDBY)
    else $error("single shot did not return to stand-by");

endmodule // irms_top

// *** irms_pkg.sv ***
// Package of constants and types for the IR measurement sequencer
package irms_pkg;

  // ----------------------------------------------------------------
  // Mode selector codes
  // ----------------------------------------------------------------
  localparam logic [2:0] MODE_STANDBY = 3'h0;
  localparam logic [2:0] MODE_SINGLE  = 3'h2;
  localparam logic [2:0] MODE_CONT0   = 3'h4;
  localparam logic [2:0] MODE_CONT1   = 3'h5;
  localparam logic [2:0] MODE_CONT2   = 3'h6;
  localparam logic [2:0] MODE_CONT3   = 3'h7;

  // ----------------------------------------------------------------
  // Register offsets
  // ----------------------------------------------------------------
  localparam logic [7:0] ADDR_STATUS1 = 8'h05;
  localparam logic [7:0] ADDR_DATA_LO = 8'h06;
  localparam logic [7:0] ADDR_DATA_HI = 8'h0F;
  localparam logic [7:0] ADDR_STATUS2 = 8'h10;
  localparam logic [7:0] ADDR_IRQ_EN  = 8'h11;
  localparam logic [7:0] ADDR_CTRL    = 8'h1C;
  localparam logic [7:0] ADDR_IRQ_ST  = 8'h20;
  localparam logic [7:0] ADDR_IRQ_MSK = 8'h21;

  // ----------------------------------------------------------------
  // Field positions and reset values
  // ----------------------------------------------------------------
  localparam int         ST1_DATA_READY_FLAG_BIT   = 0;
  localparam int         ST1_DOR_BIT    = 1;
  localparam int         CTRL_MODE_LSB  = 0;
  localparam int         CTRL_FC_LSB    = 3;
  localparam int         IRQ_EV_DONE    = 0;
  localparam int         IRQ_EV_SKIP    = 1;
  localparam logic [7:0] CTRL_RESET     = 8'h00;
  localparam logic [7:0] IRQ_EN_RESET   = 8'h00;
  localparam logic [1:0] IRQ_MSK_RESET  = 2'h0;

  // ----------------------------------------------------------------
  // Timing: base measurement time per filter step
  // ----------------------------------------------------------------
  localparam int MEAS_BASE_US = 100;
  localparam int CLK_MHZ      = 200;
  localparam int MEAS_BASE_CYC = MEAS_BASE_US * CLK_MHZ;

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic       wr;
    logic       rd;
  } irms_bus_s;

  typedef enum logic [1:0] {
    SEQ_IDLE = 2'b00,
    SEQ_MEAS = 2'b01,
    SEQ_WAIT = 2'b10,
    SEQ_HOLD = 2'b11
  } irms_seq_e;

endpackage

// *** irms_timer.sv ***
// Cycle timer that pulses once after a loaded count has run out
`timescale 1ns/100ps
module irms_timer #(
  parameter int WIDTH = 32
) (
  // Clock and reset
  input  wire logic             i_clock,
  input  wire logic             i_rst,
  // Control
  input  wire logic             i_load,
  input  wire logic             i_stop,
  input  wire logic [WIDTH-1:0] i_count,
  // Status
  output logic                  o_done
);

  logic [WIDTH-1:0] cnt_q;
  logic [WIDTH-1:0] cnt_d;
  logic             run_q;
  logic             run_d;
  logic             done_q;
  logic             done_d;

  always_comb
  begin
    cnt_d  = cnt_q;
    run_d  = run_q;
    done_d = 1'b0;
    if (i_stop)
    begin
      run_d = 1'b0;
    end
    else if (i_load)
    begin
      cnt_d = i_count;
      run_d = 1'b1;
    end
    else if (run_q)
    begin
      if (cnt_q <= WIDTH'(1))
      begin
        run_d  = 1'b0;
        done_d = 1'b1;
      end
      else
      begin
        cnt_d = cnt_q - WIDTH'(1);
      end
    end
  end

  always_ff @(posedge i_clock)
  begin
    if (i_rst)
    begin
      cnt_q  <= '0;
      run_q  <= 1'b0;
      done_q <= 1'b0;
    end
    else
    begin
      cnt_q  <= cnt_d;
      run_q  <= run_d;
      done_q <= done_d;
    end
  end

  assign o_done = done_q;

endmodule // irms_timer

// *** irms_host_model.sv ***
// Host model that drives the register port of the sequencer
`timescale 1ns/100ps
module irms_host_model (
  // Clock
  input  wire logic       i_clock,
  // Register port
  output logic      [7:0] o_addr,
  output logic      [7:0] o_wdata,
  output logic            o_wr,
  output logic            o_rd
);
  initial
  begin
    o_addr  = 8'h00;
    o_wdata = 8'h00;
    o_wr    = 1'b0;
    o_rd    = 1'b0;
  end

  // ----------------------------------------------------------------
  // One strobe cycle; callers pass stand-by between modes, close each
  // read-out with status two and read data after ready except once after the abort
  // ----------------------------------------------------------------
  task automatic access(input logic [7:0] a, input logic [7:0] d,
                        input logic w);
  begin
    @(posedge i_clock);
    o_addr  <= a;
    o_wdata <= d;
    o_wr    <= w;
    o_rd    <= ~w;
    @(posedge i_clock);
    o_wr    <= 1'b0;
    o_rd    <= 1'b0;
    // Released lines must not keep the last value
    o_addr  <= ~a;
    o_wdata <= ~d;
  end
  endtask
endmodule // irms_host_model

// *** irms_top_tb_top.sv ***
// Self-checking bench for the measurement sequencer
`timescale 1ns/100ps
module irms_top_tb_top;
  localparam int         MC  = 20;
  localparam logic [7:0] ST1 = irms_pkg::ADDR_STATUS1;
  localparam logic [7:0] ST2 = irms_pkg::ADDR_STATUS2;
  localparam logic [7:0] DAT = irms_pkg::ADDR_DATA_LO;
  localparam logic [7:0] CTL = irms_pkg::ADDR_CTRL;
  localparam logic [7:0] IST = irms_pkg::ADDR_IRQ_ST;
  localparam logic [7:0] MSK = irms_pkg::ADDR_IRQ_MSK;
  logic        i_clock;
  logic        i_rst;
  logic [7:0]  addr;
  logic [7:0]  wdata;
  logic        wr;
  logic        rd;
  logic        rd_d = 1'b0;
  logic [7:0]  rdata;
  logic [79:0] result = '0;
  logic        o_int;
  logic        data_irq;
  logic [31:0] lfsr = 32'hB9D9AE24;
  logic [8:0]  exp_q[$];
  logic [8:0]  note;
  logic [79:0] r1;
  logic [79:0] r2;
  int          n_fail = 0;
  int          n_compared = 0;
  int          cyc = 0;
  int          t;
  int          p;

  irms_top #(.MEAS_CYC(32'(MC))) uut (
    .i_clock(i_clock), .i_rst(i_rst), .i_addr(addr), .i_wdata(wdata),
    .i_wr(wr), .i_rd(rd), .o_rdata(rdata), .i_result(result),
    .o_int(o_int), .o_data_irq(data_irq));
  irms_host_model host (
    .i_clock(i_clock), .o_addr(addr), .o_wdata(wdata), .o_wr(wr),
    .o_rd(rd));

  initial
  begin
    i_clock = 1'b0;
    forever #2.5 i_clock = ~i_clock;
  end

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  task automatic check(input string nm, input logic [7:0] e,
                       input logic [7:0] g);
  begin
    n_compared = n_compared + 1;
    if (g !== e)
    begin
      n_fail = n_fail + 1;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
    end
  end
  endtask

  task automatic complete_run();
  begin
    $display("compared %0d failed %0d", n_compared, n_fail);
    if (n_fail == 0 && n_compared > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  end
  endtask

  // Hang guard: the whole sequence needs well under 3000 cycles
  always @(posedge i_clock)
  begin
    cyc <= cyc + 1;
    if (cyc == 6000)
    begin
      n_fail = n_fail + 1;
      complete_run();
    end
  end

  // Read data stand only in the cycle after the strobe
  always @(posedge i_clock)
  begin
    rd_d <= rd;
    if (rd_d && exp_q.size() > 0)
    begin
      note = exp_q.pop_front();
      if (note[8])
        check("rdata", note[7:0], rdata);
    end
  end

  function automatic logic [79:0] next_rand();
    logic [79:0] v;
    v = '0;
    for (int i = 0; i < 3; i++)
    begin
      lfsr = {lfsr[30:0], lfsr[31] ^ lfsr[21] ^ lfsr[1] ^ lfsr[0]};
      v = {v[47:0], lfsr};
    end
    return v;
  endfunction

  task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
    host.access(a, d, 1'b1);
  endtask

  // Bit 8 of the note says whether the byte is compared
  task automatic rd_reg(input logic [7:0] a, input logic [8:0] n);
  begin
    exp_q.push_back(n);
    host.access(a, 8'h00, 1'b0);
  end
  endtask

  task automatic wait_irq(output int n);
  begin
    n = 0;
    while (data_irq !== 1'b1 && n < 400)
    begin
      @(posedge i_clock);
      n = n + 1;
    end
    if (n >= 400)
      check("irq wait", 8'h01, 8'h00);
  end
  endtask

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial
  begin
    i_rst = 1'b1;
    repeat (12) @(posedge i_clock);
    i_rst <= 1'b0;
    rd_reg(ST1, 9'h100);
    rd_reg(MSK, 9'h100);
    wr_reg(8'h30, 8'hFF);
    rd_reg(8'h30, 9'h100);
    wr_reg(irms_pkg::ADDR_IRQ_EN, 8'h01);
    $display("reset and register port done");
    // Protection holds old data while newer results are skipped
    r1 = next_rand();
    result <= r1;
    wr_reg(CTL, 8'h04);
    wait_irq(t);
    check("int", 8'h01, {7'h00, o_int});
    rd_reg(ST1, 9'h101);
    rd_reg(DAT, {1'b1, r1[7:0]});
    r2 = next_rand();
    result <= r2;
    repeat (45) @(posedge i_clock);
    rd_reg(DAT + 8'h09, {1'b1, r1[79:72]});
    rd_reg(ST2, 9'h103);
    repeat (25) @(posedge i_clock);
    wr_reg(CTL, 8'h00);
    rd_reg(ST1, 9'h103);
    rd_reg(DAT, {1'b1, r2[7:0]});
    rd_reg(ST1, 9'h100);
    rd_reg(ST2, 9'h101);
    $display("protected read-out done");
    // Unread results, then an aborted measurement
    wr_reg(CTL, 8'h04);
    repeat (50) @(posedge i_clock);
    wr_reg(CTL, 8'h00);
    rd_reg(ST1, 9'h103);
    rd_reg(ST2, 9'h000);
    rd_reg(ST1, 9'h100);
    r1 = next_rand();
    result <= r1;
    wr_reg(CTL, 8'h04);
    repeat (8) @(posedge i_clock);
    wr_reg(CTL, 8'h00);
    repeat (150) @(posedge i_clock);
    rd_reg(ST1, 9'h100);
    rd_reg(DAT, {1'b1, r2[7:0]});
    rd_reg(ST2, 9'h000);
    $display("skip and abort done");
    // Repeat period of every repeating mode, then back to back at
    // filter step one, whose slot is twice as long
    for (int m = 0; m < 5; m++)
    begin
      p = (m == 4) ? 2 * MC : MC * (1 << m);
      wr_reg(CTL, (m == 4) ? 8'h0C : 8'(8'h04 + m));
      wait_irq(t);
      rd_reg(ST2, 9'h000);
      repeat (3) @(posedge i_clock);
      wait_irq(t);
      check("period", 8'h01, {7'h00, (t > p - 12) && (t < p + 4)});
      wr_reg(CTL, 8'h00);
      rd_reg(ST2, 9'h000);
      repeat (3) @(posedge i_clock);
    end
    $display("mode periods done");
    // Single shot, all ten bytes, then automatic stand-by
    r1 = next_rand();
    result <= r1;
    wr_reg(CTL, 8'h02);
    wait_irq(t);
    rd_reg(ST1, 9'h101);
    for (int b = 0; b < 10; b++)
      rd_reg(DAT + 8'(b), {1'b1, r1[8*b +: 8]});
    rd_reg(ST2, 9'h000);
    repeat (3) @(posedge i_clock);
    rd_reg(CTL, 9'h100);
    $display("single shot done");
    // Sticky events, write one to clear, mask
    rd_reg(IST, 9'h103);
    wr_reg(IST, 8'h03);
    rd_reg(IST, 9'h100);
    wr_reg(MSK, 8'h03);
    rd_reg(MSK, 9'h103);
    repeat (3) @(posedge i_clock);
    check("int", 8'h00, {7'h00, o_int});
    $display("interrupt registers done");
    complete_run();
  end
endmodule // irms_top_tb_top
